// file: msw_defines.vh
`ifndef MSW_DEFINES_VH
`define MSW_DEFINES_VH
// Register addresses (7-bit, wordwise).
`define MSW_ADDR_MODE_SUPPLY   7'h01
`define MSW_ADDR_HW_CONFIG     7'h02
`define MSW_ADDR_WATCHDOG      7'h03
// Mode field codes.
`define MSW_MODE_NORMAL        2'h0
`define MSW_MODE_SLEEP         2'h1
`define MSW_MODE_STOP          2'h2
`define MSW_MODE_SOFTRST       2'h3
// Second regulator codes.
`define MSW_VCC2_OFF           2'h0
`define MSW_VCC2_NORMAL        2'h1
`define MSW_VCC2_NORM_STOP     2'h2
`define MSW_VCC2_ALWAYS        2'h3
// Reset values.
`define MSW_RST_MODE_SUPPLY    8'h00
`define MSW_RST_HW_CONFIG      8'h00
`define MSW_RST_WATCHDOG       8'h14
// Writable masks; reserved bits are zero.
`define MSW_MASK_MODE_SUPPLY   8'hff
`define MSW_MASK_HW_CONFIG     8'hfb
`define MSW_MASK_WATCHDOG      8'hf7
// Bits kept across a soft reset in the hardware config register.
`define MSW_KEEP_HW_SOFTRST    8'h88
// Frame layout.
`define MSW_FRAME_BITS         16
`define MSW_BIT_WRITE          7
`endif

// file: msw_spi_shift.v
`timescale 1ns/100ps
// Shifts one 16-bit SPI frame, LSB first, mode 0 timing on oversampled pins.
module msw_spi_shift #(
  parameter FRAME_BITS = 16
) (
  // Clock and reset
  input  wire                  i_mclk,
  input  wire                  i_reset,
  // SPI pins
  input  wire                  i_sclk,
  input  wire                  i_csn,
  input  wire                  i_mosi,
  output reg                   o_miso,
  // Frame interface
  input  wire [7:0]            i_reply,
  output reg                   o_header_ready,
  output reg                   o_frame_done,
  output reg  [FRAME_BITS-1:0] o_frame
);
  reg       sclk_d;
  reg       csn_d;
  reg [4:0] count;
  reg [7:0] reply_shift;

  always @(posedge i_mclk) begin
    if (i_reset) begin
      sclk_d         <= 1'b0;
      csn_d          <= 1'b1;
      count          <= 5'h00;
      reply_shift    <= 8'h00;
      o_miso         <= 1'b0;
      o_header_ready <= 1'b0;
      o_frame_done   <= 1'b0;
      o_frame        <= {FRAME_BITS{1'b0}};
    end else begin
      sclk_d         <= i_sclk;
      csn_d          <= i_csn;
      o_header_ready <= 1'b0;
      o_frame_done   <= 1'b0;
      if (i_csn) begin
        count <= 5'h00;
        if (!csn_d && count == FRAME_BITS[4:0]) begin
          o_frame_done <= 1'b1;
        end
      end else if (i_sclk && !sclk_d) begin
        o_frame <= {i_mosi, o_frame[FRAME_BITS-1:1]};
        if (count != 5'h1f) begin
          count <= count + 5'h01;
        end
        if (count == 5'h07) begin
          o_header_ready <= 1'b1;
        end
      end else if (!i_sclk && sclk_d) begin
        if (count == 5'h08) begin
          o_miso      <= i_reply[0];
          reply_shift <= {1'b0, i_reply[7:1]};
        end else begin
          o_miso      <= reply_shift[0];
          reply_shift <= {1'b0, reply_shift[7:1]};
        end
      end
    end
  end
endmodule // msw_spi_shift

// file: msw_ctrl_regs.v
// Behaviour
// - Mode bits 7:6 select normal, sleep, stop, or soft reset.
// - A write requesting sleep while in stop mode keeps the mode field at stop; its other bits are written.
// - Entering restart rewrites the mode field to normal.
// - Second regulator field clears to off on restart and overtemperature.
// - Write frames return the register content from before the write.
// - Bit 5 switches the auxiliary regulator off or on.
// - Bits 4:3 select second regulator off, normal, normal+stop, always.
// - Overvoltage always flags; bit 2 also requests restart or fail-safe.
// - Bits 1:0 select one of four main reset thresholds.
// - Hardware bit 7 selects auxiliary voltage same or alternate.
// - Hardware bit 6 suppresses reset output pulse during soft reset.
// - Hardware bit 5 turns failure outputs on by software.
// - Failure-triggered outputs persist until failure status is cleared.
// - Restart clears the software failure-output bit.
// - Hardware bit 4 keeps auxiliary regulator on at low supply.
// - Hardware bit 3 selects stand-alone or load-sharing operation.
// - Hardware bit 1 enables load sharing in stop mode.
// - Hardware bit 0 picks failure count one or two for restart.
// - Soft reset keeps voltage-select and load-share; power-on clears all.
// - Watchdog bit 6 requests watchdog disable in stop mode.
// - Watchdog bit 5 selects time-out or window watchdog.
// - Watchdog bit 4 lets bus wake in stop start the watchdog.
// - Control bits hold their value unless hardware modifies them.
`timescale 1ns/100ps
`include "msw_defines.vh"
module msw_ctrl_regs (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_reset,
  // SPI pins
  input  wire       i_sclk,
  input  wire       i_csn,
  input  wire       i_mosi,
  // System events
  input  wire       i_restart_entry,
  input  wire       i_overtemperature,
  input  wire       i_main_overvoltage,
  input  wire       i_failure_status,
  input  wire       i_supply_undervoltage,
  input  wire       i_bus_wake,
  input  wire       i_wd_period_load,
  input  wire [2:0] i_wd_period_value,
  // SPI data out
  output reg        o_miso,
  // Mode outputs
  output reg  [1:0] o_mode,
  output reg        o_soft_reset,
  output reg        o_reset_output_n,
  // Supply outputs
  output reg        o_aux_reg_on,
  output reg        o_aux_voltage_alt,
  output reg        o_aux_load_share_on,
  output reg        o_second_reg_on,
  output reg  [1:0] o_main_reset_threshold,
  output reg        o_main_ov_flag,
  output reg        o_main_ov_restart_req,
  output reg        o_wd_fail_single,
  // Failure outputs
  output reg        o_failure_outputs,
  // Watchdog outputs
  output reg        o_wd_stop_disable_lo,
  output reg        o_wd_window_select,
  output reg        o_wd_bus_start,
  output reg  [2:0] o_wd_period_select,
  output reg        o_wd_parity_error
);
  reg  [7:0]  mode_supply_control;
  reg  [7:0]  hardware_config_control;
  reg  [7:0]  watchdog_control;
  reg  [7:0]  next_ms;
  reg  [7:0]  next_hw;
  reg  [7:0]  next_wd;
  reg  [7:0]  reply_latch;
  reg  [7:0]  read_mux;
  reg         soft_pending;
  wire        header_ready;
  wire        frame_done;
  wire [15:0] frame;
  wire [6:0]  addr  = frame[6:0];
  wire        wr    = frame[`MSW_BIT_WRITE];
  wire [7:0]  wdata = frame[15:8];

  function [7:0] msw_read;
    input [6:0] a;
    input [7:0] ms;
    input [7:0] hw;
    input [7:0] wd;
    begin
      case (a)
        `MSW_ADDR_MODE_SUPPLY: msw_read = ms;
        `MSW_ADDR_HW_CONFIG:   msw_read = hw & `MSW_MASK_HW_CONFIG;
        `MSW_ADDR_WATCHDOG:    msw_read = wd & `MSW_MASK_WATCHDOG;
        default:               msw_read = 8'h00;
      endcase
    end
  endfunction

  msw_spi_shift #(
    .FRAME_BITS (`MSW_FRAME_BITS)
  ) u_shift (
    .i_mclk         (i_mclk),
    .i_reset        (i_reset),
    .i_sclk         (i_sclk),
    .i_csn          (i_csn),
    .i_mosi         (i_mosi),
    .o_miso         (),
    .i_reply        (reply_latch),
    .o_header_ready (header_ready),
    .o_frame_done   (frame_done),
    .o_frame        ()
  );

  // Local copy of the frame, captured from the same pin timing.
  reg        sclk_d;
  reg [15:0] shreg;
  reg [4:0]  bitn;
  reg [7:0]  out_sh;
  assign frame = shreg;

  always @(posedge i_mclk) begin
    if (i_reset) begin
      sclk_d <= 1'b0;
      shreg  <= 16'h0000;
      bitn   <= 5'h00;
      out_sh <= 8'h00;
      o_miso <= 1'b0;
    end else begin
      sclk_d <= i_sclk;
      if (i_csn) begin
        bitn <= 5'h00;
      end else if (i_sclk && !sclk_d) begin
        shreg <= {i_mosi, shreg[15:1]};
        if (bitn != 5'h1f) begin
          bitn <= bitn + 5'h01;
        end
      end else if (!i_sclk && sclk_d) begin
        if (bitn == 5'h08) begin
          o_miso <= reply_latch[0];
          out_sh <= {1'b0, reply_latch[7:1]};
        end else begin
          o_miso <= out_sh[0];
          out_sh <= {1'b0, out_sh[7:1]};
        end
      end
    end
  end

  // Header decoded after bit 7: old content is latched as the reply.
  always @(posedge i_mclk) begin
    if (i_reset) begin
      reply_latch <= 8'h00;
    end else if (header_ready) begin
      reply_latch <= read_mux;
    end
  end

  always @* begin
    // After eight rising edges the header sits in the top byte of shreg.
    read_mux = msw_read(shreg[14:8], mode_supply_control,
                        hardware_config_control, watchdog_control);
  end

  always @* begin
    next_ms = mode_supply_control;
    next_hw = hardware_config_control;
    next_wd = watchdog_control;
    if (frame_done && wr) begin
      case (addr)
        `MSW_ADDR_MODE_SUPPLY: begin
          next_ms = wdata;
          if (mode_supply_control[7:6] == `MSW_MODE_STOP &&
              wdata[7:6] == `MSW_MODE_SLEEP) begin
            next_ms[7:6] = mode_supply_control[7:6];
          end
        end
        `MSW_ADDR_HW_CONFIG: next_hw = wdata & `MSW_MASK_HW_CONFIG;
        `MSW_ADDR_WATCHDOG:  next_wd = wdata & `MSW_MASK_WATCHDOG;
        default: next_ms = mode_supply_control;
      endcase
    end
    if (i_wd_period_load) begin
      next_wd[2:0] = i_wd_period_value;
    end
    if (i_overtemperature) begin
      next_ms[4:3] = `MSW_VCC2_OFF;
    end
    if (i_restart_entry) begin
      next_ms[7:6] = `MSW_MODE_NORMAL;
      next_ms[4:3] = `MSW_VCC2_OFF;
      next_hw[5]   = 1'b0;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      mode_supply_control     <= `MSW_RST_MODE_SUPPLY;
      hardware_config_control <= `MSW_RST_HW_CONFIG;
      watchdog_control        <= `MSW_RST_WATCHDOG;
      soft_pending            <= 1'b0;
      o_wd_parity_error       <= 1'b0;
    end else if (soft_pending) begin
      mode_supply_control     <= `MSW_RST_MODE_SUPPLY;
      hardware_config_control <= hardware_config_control &
                                 `MSW_KEEP_HW_SOFTRST;
      watchdog_control        <= `MSW_RST_WATCHDOG;
      soft_pending            <= 1'b0;
    end else begin
      mode_supply_control     <= next_ms;
      hardware_config_control <= next_hw;
      watchdog_control        <= next_wd;
      soft_pending            <= (next_ms[7:6] == `MSW_MODE_SOFTRST);
      if (frame_done && wr && addr == `MSW_ADDR_WATCHDOG) begin
        o_wd_parity_error <= ^wdata;
      end
    end
  end

  // Decoded outputs, all registered.
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_mode                 <= `MSW_MODE_NORMAL;
      o_soft_reset           <= 1'b0;
      o_reset_output_n       <= 1'b1;
      o_aux_reg_on           <= 1'b0;
      o_aux_voltage_alt      <= 1'b0;
      o_aux_load_share_on    <= 1'b0;
      o_second_reg_on        <= 1'b0;
      o_main_reset_threshold <= 2'h0;
      o_main_ov_flag         <= 1'b0;
      o_main_ov_restart_req  <= 1'b0;
      o_wd_fail_single       <= 1'b0;
      o_failure_outputs      <= 1'b0;
      o_wd_stop_disable_lo   <= 1'b0;
      o_wd_window_select     <= 1'b0;
      o_wd_bus_start         <= 1'b0;
      o_wd_period_select     <= 3'h0;
    end else begin
      o_mode       <= mode_supply_control[7:6];
      o_soft_reset <= soft_pending;
      o_reset_output_n <= !(soft_pending &&
                            !hardware_config_control[6]);
      o_aux_reg_on <= mode_supply_control[5] &&
                      (hardware_config_control[4] ||
                       !i_supply_undervoltage);
      o_aux_voltage_alt <= hardware_config_control[7];
      o_aux_load_share_on <= hardware_config_control[3] &&
                             (mode_supply_control[7:6] != `MSW_MODE_STOP ||
                              hardware_config_control[1]);
      case (mode_supply_control[4:3])
        `MSW_VCC2_NORMAL:
          o_second_reg_on <= mode_supply_control[7:6] == `MSW_MODE_NORMAL;
        `MSW_VCC2_NORM_STOP:
          o_second_reg_on <= mode_supply_control[7:6] == `MSW_MODE_NORMAL ||
                             mode_supply_control[7:6] == `MSW_MODE_STOP;
        `MSW_VCC2_ALWAYS: o_second_reg_on <= 1'b1;
        default:          o_second_reg_on <= 1'b0;
      endcase
      o_main_reset_threshold <= mode_supply_control[1:0];
      o_main_ov_flag <= i_main_overvoltage;
      o_main_ov_restart_req <= i_main_overvoltage &&
                               mode_supply_control[2];
      o_wd_fail_single <= hardware_config_control[0];
      o_failure_outputs <= hardware_config_control[5] ||
                           i_failure_status;
      o_wd_stop_disable_lo <= watchdog_control[6];
      o_wd_window_select   <= watchdog_control[5];
      o_wd_bus_start <= watchdog_control[4] && i_bus_wake &&
                        mode_supply_control[7:6] == `MSW_MODE_STOP;
      o_wd_period_select <= watchdog_control[2:0];
    end
  end
endmodule // msw_ctrl_regs

// file: msw_ctrl_regs_sva.sv
`timescale 1ns/100ps
module msw_ctrl_regs_sva (
  // Clock and reset
  input wire       i_mclk,
  input wire       i_reset,
  // Watched signals
  input wire       i_restart_entry,
  input wire       i_main_overvoltage,
  input wire [1:0] o_mode,
  input wire       o_soft_reset,
  input wire       o_reset_output_n,
  input wire       o_main_ov_flag,
  input wire       o_main_ov_restart_req,
  input wire       o_second_reg_on
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_ov_flag_follow: assert property (
    !$past(i_reset) |-> o_main_ov_flag == $past(i_main_overvoltage))
    else $error("overvoltage flag does not follow its input");
  a_ov_req_gated: assert property (
    o_main_ov_restart_req |-> o_main_ov_flag)
    else $error("restart request without overvoltage flag");
  a_srst_one_pulse: assert property (
    o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse longer than one cycle");
  a_srst_to_normal: assert property (
    o_soft_reset |-> ##[0:3] o_mode == 2'h0)
    else $error("mode not normal after soft reset");
  a_rst_out_short: assert property (
    !o_reset_output_n |=> o_reset_output_n)
    else $error("reset output low too long");
  a_rst_out_cause: assert property (
    $fell(o_reset_output_n) |-> o_soft_reset || $past(o_soft_reset)
      || $past(o_soft_reset, 2))
    else $error("reset output low without soft reset");
  a_no_stop_sleep: assert property (
    o_mode == 2'h2 |=> o_mode != 2'h1)
    else $error("stop mode went straight to sleep");
  a_restart_normal: assert property (
    i_restart_entry |-> ##[1:3] (o_mode == 2'h0 && !o_second_reg_on))
    else $error("restart did not restore normal mode");
endmodule // msw_ctrl_regs_sva

// file: msw_host_model.sv
`timescale 1ns/100ps
module msw_host_model (
  // Clock
  input  wire  i_mclk,
  // SPI pins
  input  wire  i_miso,
  output logic o_sclk,
  output logic o_csn,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_csn  = 1'b1;
    o_mosi = 1'b0;
  end
  // One 16-bit frame, LSB first, four clocks per serial half period.
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {d, wr, a};
    q = 8'h00;
    @(posedge i_mclk) o_csn <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_mosi <= f[i];
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      if (i >= 8) q[i-8] = i_miso;
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_mclk);
    o_csn  <= 1'b1;
    o_mosi <= ~f[15];
    repeat (4) @(posedge i_mclk);
  endtask
endmodule // msw_host_model

// file: msw_ctrl_regs_test.sv
`timescale 1ns/100ps
module msw_ctrl_regs_test;
  logic       i_mclk, i_reset, i_restart_entry, i_overtemperature;
  logic       i_main_overvoltage, i_failure_status, i_supply_undervoltage;
  logic       i_bus_wake, i_wd_period_load, low_seen;
  logic [2:0] i_wd_period_value;
  logic [7:0] ms, hw, wd, r;
  int         err_count, cmp_count, cyc, k;
  wire        i_sclk, i_csn, i_mosi, o_miso, o_soft_reset, o_reset_output_n;
  wire        o_aux_reg_on, o_aux_voltage_alt, o_aux_load_share_on;
  wire        o_second_reg_on, o_main_ov_flag, o_main_ov_restart_req;
  wire        o_wd_fail_single, o_failure_outputs, o_wd_stop_disable_lo;
  wire        o_wd_window_select, o_wd_bus_start, o_wd_parity_error;
  wire  [1:0] o_mode, o_main_reset_threshold;
  wire  [2:0] o_wd_period_select;
  msw_ctrl_regs msw_ctrl_regs_inst (.i_mclk, .i_reset, .i_sclk, .i_csn,
    .i_mosi, .i_restart_entry, .i_overtemperature, .i_main_overvoltage,
    .i_failure_status, .i_supply_undervoltage, .i_bus_wake,
    .i_wd_period_load, .i_wd_period_value, .o_miso, .o_mode, .o_soft_reset,
    .o_reset_output_n, .o_aux_reg_on, .o_aux_voltage_alt,
    .o_aux_load_share_on, .o_second_reg_on, .o_main_reset_threshold,
    .o_main_ov_flag, .o_main_ov_restart_req, .o_wd_fail_single,
    .o_failure_outputs, .o_wd_stop_disable_lo, .o_wd_window_select,
    .o_wd_bus_start, .o_wd_period_select, .o_wd_parity_error);
  msw_host_model msw_host_model_inst (.i_mclk, .i_miso(o_miso),
    .o_sclk(i_sclk), .o_csn(i_csn), .o_mosi(i_mosi));
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (o_reset_output_n === 1'b0) low_seen <= 1'b1;
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      conclude;
    end
  end
  task conclude;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task acc(input logic wr, input logic [6:0] a, input logic [7:0] d,
           input logic [7:0] exp);
    logic [7:0] q;
    msw_host_model_inst.xfer(wr, a, d, q);
    check(q, exp);
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  function logic [7:0] par(input logic [7:0] x);
    return {^x[6:0], x[6:0]};
  endfunction
  function logic v2on(input logic [7:0] m);
    case (m[4:3])
      2'h0: return 1'b0;
      2'h1: return m[7:6] == 2'h0;
      2'h2: return m[7:6] == 2'h0 || m[7:6] == 2'h2;
      default: return 1'b1;
    endcase
  endfunction
  task outs;
    check(o_mode, ms[7:6]);
    check(o_second_reg_on, v2on(ms));
    check(o_aux_reg_on,
          ms[5] & (hw[4] | !i_supply_undervoltage));
    check(o_main_reset_threshold, ms[1:0]);
    check(o_aux_voltage_alt, hw[7]);
    check(o_failure_outputs, hw[5]);
    check(o_aux_load_share_on,
          hw[3] & (ms[7:6] != 2'h2 | hw[1]));
    check(o_wd_fail_single, hw[0]);
    check(o_wd_stop_disable_lo, wd[6]);
    check(o_wd_window_select, wd[5]);
    check(o_wd_period_select, wd[2:0]);
    check(o_wd_parity_error, 1'b0);
  endtask
  initial begin
    {i_mclk, i_restart_entry, i_overtemperature, i_main_overvoltage} = 4'h0;
    {i_failure_status, i_supply_undervoltage, i_bus_wake} = 3'h0;
    {i_wd_period_load, i_wd_period_value, low_seen} = 5'h00;
    i_reset = 1'b1;
    {ms, hw, wd} = 24'h00_0014;
    r = 8'($urandom(32'h0000_07db));
    tick(12);
    i_reset <= 1'b0;
    tick(2);
    acc(1'b0, 7'h01, 8'h00, ms);
    acc(1'b0, 7'h02, 8'h00, hw);
    acc(1'b0, 7'h03, 8'h00, wd);
    for (k = 0; k < 20; k++) begin
      r = 8'($urandom);
      i_supply_undervoltage <= r[0];
      r[7:6] = r[7:6] % 3;
      acc(1'b1, 7'h01, r, ms);
      if (!(ms[7:6] == 2'h2 && r[7:6] == 2'h1)) ms[7:6] = r[7:6];
      ms[5:0] = r[5:0];
      r = 8'($urandom);
      acc(1'b1, 7'h02, r, hw);
      hw = r & 8'hfb;
      r = par(8'($urandom));
      acc(1'b1, 7'h03, r, wd);
      wd = r & 8'hf7;
      acc(1'b0, 7'h01, 8'h00, ms);
      acc(1'b0, 7'h02, 8'h00, hw);
      acc(1'b0, 7'h03, 8'h00, wd);
      outs;
    end
    acc(1'b1, 7'h01, 8'h80, ms);
    acc(1'b1, 7'h01, 8'h40, 8'h80);
    acc(1'b0, 7'h01, 8'h00, 8'h80);
    acc(1'b1, 7'h03, 8'h90, wd);
    i_bus_wake <= 1'b1;
    tick(3);
    check(o_wd_bus_start, 1'b1);
    i_bus_wake <= 1'b0;
    i_wd_period_load <= 1'b1;
    i_wd_period_value <= 3'h5;
    tick(1);
    i_wd_period_load <= 1'b0;
    tick(3);
    acc(1'b1, 7'h03, 8'h01, 8'h95);
    check(o_wd_parity_error, 1'b1);
    acc(1'b1, 7'h05, 8'hff, 8'h00);
    acc(1'b0, 7'h05, 8'h00, 8'h00);
    acc(1'b1, 7'h01, 8'h1c, 8'h80);
    i_main_overvoltage <= 1'b1;
    tick(3);
    check(o_main_ov_restart_req, 1'b1);
    i_main_overvoltage <= 1'b0;
    acc(1'b1, 7'h02, 8'h20, hw);
    i_failure_status <= 1'b1;
    acc(1'b1, 7'h02, 8'h00, 8'h20);
    check(o_failure_outputs, 1'b1);
    i_failure_status <= 1'b0;
    acc(1'b1, 7'h02, 8'h20, 8'h00);
    i_restart_entry <= 1'b1;
    tick(1);
    i_restart_entry <= 1'b0;
    tick(3);
    acc(1'b0, 7'h01, 8'h00, 8'h04);
    acc(1'b0, 7'h02, 8'h00, 8'h00);
    check(o_failure_outputs, 1'b0);
    acc(1'b1, 7'h01, 8'h08, 8'h04);
    i_overtemperature <= 1'b1;
    tick(1);
    i_overtemperature <= 1'b0;
    tick(3);
    acc(1'b0, 7'h01, 8'h00, 8'h00);
    hw = 8'h00;
    for (k = 0; k < 2; k++) begin
      r = (k == 0) ? 8'h9f : 8'hdf;
      acc(1'b1, 7'h02, r, hw);
      low_seen = 1'b0;
      acc(1'b1, 7'h01, 8'hc0, 8'h00);
      // The low pulse is recorded at the edge on which the frame returns.
      tick(1);
      check(low_seen, k == 0);
      acc(1'b0, 7'h02, 8'h00, 8'h88);
      acc(1'b0, 7'h03, 8'h00, 8'h14);
      hw = 8'h88;
    end
    conclude;
  end
endmodule // msw_ctrl_regs_test
bind msw_ctrl_regs msw_ctrl_regs_sva msw_ctrl_regs_sva_inst (.i_mclk,
  .i_reset, .i_restart_entry, .i_main_overvoltage, .o_mode, .o_soft_reset,
  .o_reset_output_n, .o_main_ov_flag, .o_main_ov_restart_req,
  .o_second_reg_on);
